/* File: hdl/aih_consts.svh */
`ifndef AIH_CONSTS_SVH
`define AIH_CONSTS_SVH
// Instruction lengths in bytes
`define AIH_LEN_SHORT      4'h2
`define AIH_LEN_GENERAL_OPERAND_16      4'h6
`define AIH_LEN_GENERAL_OPERAND_32      4'hA
// Short-form opcodes
`define AIH_OP_ACC_WAI     8'h0D
`define AIH_OP_ADD_IMM     8'h14
`define AIH_OP_ACC_IMM     8'h15
`define AIH_OP_ADD_STK     8'h16
`define AIH_OP_ACC_STK     8'h17
// General-form opcodes
`define AIH_OP_ADD_GEN     8'h23
`define AIH_OP_ACC_GEN     8'h33
`define AIH_OP_LOCK_GEN    8'h03
// Stack-cache word index of the accumulator (offset 4)
`define AIH_ACC_IDX        5'h01
// Narrow operand width for the 16-bit general form
`define AIH_NARROW_MSB     15
// Reset values
`define AIH_RST_WORD       32'h00000000
`define AIH_RST_IDX        5'h00
`endif

/* File: hdl/aih_core.sv */
`timescale 1ns/1ps
`default_nettype none
`include "aih_consts.svh"
// Functional notes
// - Flag tests see fresh carry, overflow
// - Narrow overflow may forward untruncated 17-bit value
// - Add writes destination; accumulator form writes accumulator
// - Carry on unsigned, overflow on signed overflow
// - Length 10 same opcodes, 32-bit width
// - Interlocked: destination gets sum, accumulator old
// - Lock from destination fetch to store done
// - No other access inside locked pair
// - Accumulator memory store after locked pair
// - Interlocked add keeps carry and overflow
// - Stack offset: word index, offsets 0..124
// - Scaled immediate zero-extended times four
// - Signed immediate is two's complement
// - Accumulator is stack word at offset 4
// - Drain pipeline before interlocked, admit none
// - Accumulator write wins when destination is accumulator
module aih_core (
	input  wire logic                  clk,
	input  wire logic                  sys_rst,
	input  wire logic                  instr_valid,
	input  wire aih_pkg::aih_instr_t   instr,
	output var  logic                  instr_ready,
	output var  logic                  instr_bad,
	output var  logic                  done,
	input  wire logic                  pipe_empty,
	input  wire logic                  acc_in_cache,
	input  wire logic [31:0]           acc_mem_addr,
	output var  aih_pkg::aih_bus_t     bus_out,
	input  wire aih_pkg::aih_bus_rsp_t bus_rsp,
	output var  logic                  carry_flag,
	output var  logic                  overflow_flag,
	output var  logic [31:0]           fwd_result,
	output var  logic                  fwd_valid
);
	import aih_pkg::*;

	typedef enum logic [3:0] {S_IDLE, S_DRAIN, S_READ, S_FETCH, S_MRD, S_EXEC, S_MWR, S_ACC, S_AWR} aih_state_t;

	// Opcode and length to control word
	function automatic aih_dec_t aih_decode(input logic [3:0] len, input logic [7:0] op);
		aih_dec_t d;
		d = '0;
		d.smode = SM_GEN;
		if (len == `AIH_LEN_SHORT)
		begin
			d.wide = 1'b1;                  // stack_offset_5 operands are words
			case (op)
				`AIH_OP_ACC_WAI: begin d.ok = 1'b1; d.acc = 1'b1; d.smode = SM_WAI; end
				`AIH_OP_ADD_IMM: begin d.ok = 1'b1; d.smode = SM_IMM; end
				`AIH_OP_ADD_STK: begin d.ok = 1'b1; d.smode = SM_STK; end
				`AIH_OP_ACC_IMM: begin d.ok = 1'b1; d.acc = 1'b1; d.smode = SM_IMM; end
				`AIH_OP_ACC_STK: begin d.ok = 1'b1; d.acc = 1'b1; d.smode = SM_STK; end
				default: d.ok = 1'b0;
			endcase
		end
		else if (len == `AIH_LEN_GENERAL_OPERAND_16 || len == `AIH_LEN_GENERAL_OPERAND_32)
		begin
			d.wide = (len == `AIH_LEN_GENERAL_OPERAND_32);
			d.dgen = 1'b1;
			case (op)
				`AIH_OP_ADD_GEN:  d.ok = 1'b1;
				`AIH_OP_ACC_GEN:  begin d.ok = 1'b1; d.acc = 1'b1; end
				`AIH_OP_LOCK_GEN: begin d.ok = 1'b1; d.lock = 1'b1; end
				default: d.ok = 1'b0;
			endcase
		end
		return d;
	endfunction : aih_decode

	// Add with flags at the operand width, sum kept untruncated
	function automatic aih_add_t aih_add(input logic [31:0] a, input logic [31:0] b, input logic wide);
		aih_add_t r;
		logic [32:0] s33;
		logic [16:0] s17;
		s33 = {1'b0, a} + {1'b0, b};
		s17 = {1'b0, a[15:0]} + {1'b0, b[15:0]};
		if (wide)
		begin
			r.sum   = s33[31:0];
			r.carry = s33[32];
			r.ovf   = (a[31] == b[31]) && (s33[31] != a[31]);
		end
		else
		begin
			r.sum   = {15'h0000, s17};          // Bit 16 kept for forwarding
			r.carry = s17[16];
			r.ovf   = (a[15] == b[15]) && (s17[15] != a[15]);
		end
		return r;
	endfunction : aih_add

	aih_state_t  state, next_state;        // Sequencer
	aih_instr_t  ins, next_ins;            // Latched instruction
	aih_dec_t    dec, next_dec;            // Latched decode
	logic [31:0] src_val, next_src_val;    // Source operand
	logic [31:0] dst_old, next_dst_old;    // Destination before the add
	logic [31:0] sum_w, next_sum_w;        // Value written to destination
	aih_bus_t    next_bus;                 // Bus request next value
	logic        next_ready, next_bad, next_done, next_carry, next_ovf, next_fwd_valid;
	logic [31:0] next_fwd;
	logic [4:0]  rf_a_idx, rf_b_idx;       // Register-file read indices
	logic [31:0] rf_a, rf_b;               // Register-file read data
	logic        rf_we;                    // Register-file write
	logic [4:0]  rf_widx;
	logic [31:0] rf_wdata;
	logic [4:0]  dst_idx;                  // Destination word index
	logic        dst_mem;                  // Destination lies on the bus
	aih_add_t    res;                      // Adder output

	assign dst_idx = dec.dgen ? ins.gdst_idx : ins.dst_fld;
	assign dst_mem = dec.dgen && ins.gdst_mem;
	assign res     = aih_add(src_val, dst_old, dec.wide);

	aih_regfile u_rf (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.rd_a_idx  (rf_a_idx),
		.rd_b_idx  (rf_b_idx),
		.rd_a_data (rf_a),
		.rd_b_data (rf_b),
		.wr_en     (rf_we),
		.wr_idx    (rf_widx),
		.wr_data   (rf_wdata)
	);

	// Next-state, operand and bus logic
	always_comb
	begin
		next_state     = state;
		next_ins       = ins;
		next_dec       = dec;
		next_src_val   = src_val;
		next_dst_old   = dst_old;
		next_sum_w     = sum_w;
		next_bus       = bus_out;
		next_bad       = 1'b0;
		next_done      = 1'b0;
		next_carry     = carry_flag;
		next_ovf       = overflow_flag;
		next_fwd       = fwd_result;
		next_fwd_valid = 1'b0;
		rf_a_idx       = ins.src_fld;
		rf_b_idx       = dst_idx;
		rf_we          = 1'b0;
		rf_widx        = dst_idx;
		rf_wdata       = sum_w;
		case (state)
			S_IDLE:
			begin
				if (instr_valid)
				begin
					next_ins = instr;
					next_dec = aih_decode(instr.len, instr.opcode);
					if (!next_dec.ok)
						next_bad = 1'b1;             // Unknown opcode, dropped
					else if (next_dec.lock)
						next_state = S_DRAIN;
					else
						next_state = S_READ;
				end
			end
			S_DRAIN:
			begin
				// Older instructions must leave before the interlock starts
				if (pipe_empty)
					next_state = S_READ;
			end
			S_READ:
				next_state = S_FETCH;                // Read indices presented
			S_FETCH:
			begin
				case (dec.smode)
					SM_IMM:  next_src_val = {{27{ins.src_fld[4]}}, ins.src_fld};
					SM_WAI:  next_src_val = {25'h0000000, ins.src_fld, 2'b00};
					SM_STK:  next_src_val = rf_a;
					default: next_src_val = ins.gsrc;
				endcase
				next_dst_old = rf_b;
				if (dst_mem)
				begin
					// Destination fetch, locked when interlocked
					next_bus.req  = 1'b1;
					next_bus.we   = 1'b0;
					next_bus.lock = dec.lock;
					next_bus.addr = ins.gdst_addr;
					next_state    = S_MRD;
				end
				else
					next_state = S_EXEC;
			end
			S_MRD:
			begin
				if (bus_rsp.ack)
				begin
					next_bus.req = 1'b0;
					next_dst_old = bus_rsp.rdata;
					next_state   = S_EXEC;
				end
			end
			S_EXEC:
			begin
				// Narrow destination keeps its upper half
				next_sum_w = dec.wide ? res.sum : {dst_old[31:16], res.sum[`AIH_NARROW_MSB:0]};
				next_fwd       = res.sum;
				next_fwd_valid = 1'b1;
				if (!dec.lock)
				begin
					next_carry = res.carry;
					next_ovf   = res.ovf;
				end
				// Accumulator form reads a memory destination but never writes it back
				if (dst_mem && !dec.acc)
				begin
					next_bus.req   = 1'b1;
					next_bus.we    = 1'b1;
					next_bus.wdata = dec.wide ? res.sum : {dst_old[31:16], res.sum[`AIH_NARROW_MSB:0]};
					next_state     = S_MWR;
				end
				else
				begin
					rf_we    = 1'b1;
					rf_widx  = dec.acc ? `AIH_ACC_IDX : dst_idx;
					rf_wdata = dec.wide ? res.sum : {dst_old[31:16], res.sum[`AIH_NARROW_MSB:0]};
					if (dec.lock)
						next_state = S_ACC;
					else
					begin
						next_done  = 1'b1;
						next_state = S_IDLE;
					end
				end
			end
			S_MWR:
			begin
				if (bus_rsp.ack)
				begin
					next_bus.req  = 1'b0;
					next_bus.we   = 1'b0;
					next_bus.lock = 1'b0;
					if (dec.lock)
						next_state = S_ACC;
					else
					begin
						next_done  = 1'b1;
						next_state = S_IDLE;
					end
				end
			end
			S_ACC:
			begin
				// Old value to accumulator, written last so it wins
				if (acc_in_cache)
				begin
					rf_we      = 1'b1;
					rf_widx    = `AIH_ACC_IDX;
					rf_wdata   = dst_old;
					next_done  = 1'b1;
					next_state = S_IDLE;
				end
				else
				begin
					next_bus.req   = 1'b1;
					next_bus.we    = 1'b1;
					next_bus.lock  = 1'b0;
					next_bus.addr  = acc_mem_addr;
					next_bus.wdata = dst_old;
					next_state     = S_AWR;
				end
			end
			S_AWR:
			begin
				if (bus_rsp.ack)
				begin
					next_bus.req = 1'b0;
					next_bus.we  = 1'b0;
					next_done    = 1'b1;
					next_state   = S_IDLE;
				end
			end
			default:
				next_state = S_IDLE;
		endcase
		// Nothing is admitted until the current add completes
		next_ready = (next_state == S_IDLE);
	end

	// State registers
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state         <= S_IDLE;
			ins           <= '0;
			dec           <= '0;
			src_val       <= `AIH_RST_WORD;
			dst_old       <= `AIH_RST_WORD;
			sum_w         <= `AIH_RST_WORD;
			bus_out       <= '0;
			instr_ready   <= 1'b0;
			instr_bad     <= 1'b0;
			done          <= 1'b0;
			carry_flag    <= 1'b0;
			overflow_flag <= 1'b0;
			fwd_result    <= `AIH_RST_WORD;
			fwd_valid     <= 1'b0;
		end
		else
		begin
			state         <= next_state;
			ins           <= next_ins;
			dec           <= next_dec;
			src_val       <= next_src_val;
			dst_old       <= next_dst_old;
			sum_w         <= next_sum_w;
			bus_out       <= next_bus;
			instr_ready   <= next_ready;
			instr_bad     <= next_bad;
			done          <= next_done;
			carry_flag    <= next_carry;
			overflow_flag <= next_ovf;
			fwd_result    <= next_fwd;
			fwd_valid     <= next_fwd_valid;
		end
	end

	// Checks
	sequence seq_locked_store;
		bus_out.req && bus_out.we && bus_out.lock && bus_rsp.ack;
	endsequence
	sequence seq_lock_dropped;
		!bus_out.lock;
	endsequence

	a_lock_release: assert property (@(posedge clk) disable iff (sys_rst)
		seq_locked_store |=> seq_lock_dropped)
		else $error("lock not dropped after locked store");
	a_lock_cause: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(bus_out.lock) |-> $past(bus_rsp.ack && bus_out.we))
		else $error("lock dropped before store completed");
	a_lock_addr: assert property (@(posedge clk) disable iff (sys_rst)
		(bus_out.lock && bus_out.req) |-> (bus_out.addr == ins.gdst_addr))
		else $error("foreign access while locked");
	a_acc_store: assert property (@(posedge clk) disable iff (sys_rst)
		(state == S_AWR) |-> (!bus_out.lock && bus_out.wdata == dst_old))
		else $error("accumulator store overlaps lock");
	a_flags_keep: assert property (@(posedge clk) disable iff (sys_rst)
		(state == S_EXEC && dec.lock) |=> $stable(carry_flag) && $stable(overflow_flag))
		else $error("interlocked add changed flags");
	a_flags_set: assert property (@(posedge clk) disable iff (sys_rst)
		(state == S_EXEC && !dec.lock) |=> (carry_flag == $past(res.carry)) && (overflow_flag == $past(res.ovf)))
		else $error("flags not updated by add");
	a_acc_wins: assert property (@(posedge clk) disable iff (sys_rst)
		(state == S_EXEC && dec.lock && !dst_mem) |=> (rf_we == acc_in_cache)
			&& (!acc_in_cache || (rf_widx == `AIH_ACC_IDX && rf_wdata == dst_old)))
		else $error("accumulator old value not written last");
	a_no_admit: assert property (@(posedge clk) disable iff (sys_rst)
		(state == S_DRAIN) |-> !instr_ready)
		else $error("instruction admitted during interlock");
	a_drain_wait: assert property (@(posedge clk) disable iff (sys_rst)
		(state == S_DRAIN && !pipe_empty) |=> (state == S_DRAIN))
		else $error("interlock started before drain");
	a_sum_write: assert property (@(posedge clk) disable iff (sys_rst)
		(state == S_EXEC && (!dst_mem || dec.acc) && dec.wide) |-> rf_we && rf_wdata == src_val + dst_old)
		else $error("wrong sum written");
	a_fwd_pulse: assert property (@(posedge clk) disable iff (sys_rst)
		(state == S_EXEC) |=> fwd_valid && fwd_result == $past(res.sum))
		else $error("untruncated result not forwarded");
endmodule : aih_core
`default_nettype wire

/* File: hdl/aih_pkg.sv */
package aih_pkg;
	// Source operand modes
	typedef enum logic [1:0] {SM_IMM, SM_WAI, SM_STK, SM_GEN} aih_smode_t;
	// Instruction as handed in by the issue stage
	typedef struct packed {
		logic [3:0]  len;        // Encoded length 2, 6 or 10
		logic [7:0]  opcode;     // Primary opcode
		logic [4:0]  src_fld;    // Short-form source field
		logic [4:0]  dst_fld;    // Short-form destination field
		logic [31:0] gsrc;       // Resolved general source value
		logic        gdst_mem;   // General destination in memory, outside stack cache
		logic [4:0]  gdst_idx;   // General destination word index in stack cache
		logic [31:0] gdst_addr;  // General destination memory address
	} aih_instr_t;
	// Decoded control
	typedef struct packed {
		logic       ok;          // Opcode recognised
		logic       acc;         // Result goes to accumulator
		logic       lock;        // Interlocked add
		logic       wide;        // 32-bit operands
		aih_smode_t smode;       // Source mode
		logic       dgen;        // Destination is a general operand
	} aih_dec_t;
	// Memory bus request
	typedef struct packed {
		logic        req;        // Access request, held until ack
		logic        we;         // Write when high
		logic        lock;       // Bus lock, arbiter grants no one else
		logic [31:0] addr;       // Byte address
		logic [31:0] wdata;      // Write data
	} aih_bus_t;
	// Memory bus response
	typedef struct packed {
		logic        ack;        // Access complete, one-cycle pulse
		logic [31:0] rdata;      // Read data, valid with ack
	} aih_bus_rsp_t;
	// Adder result
	typedef struct packed {
		logic        carry;      // Unsigned overflow
		logic        ovf;        // Signed overflow
		logic [31:0] sum;        // Untruncated sum
	} aih_add_t;
endpackage : aih_pkg

/* File: hdl/aih_regfile.sv */
`timescale 1ns/1ps
`default_nettype none
`include "aih_consts.svh"
module aih_regfile (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic [4:0]  rd_a_idx,
	input  wire logic [4:0]  rd_b_idx,
	output var  logic [31:0] rd_a_data,
	output var  logic [31:0] rd_b_data,
	input  wire logic        wr_en,
	input  wire logic [4:0]  wr_idx,
	input  wire logic [31:0] wr_data
);
	logic [31:0] mem [0:31];    // Stack-cache words, offsets 0..124
	// Array has no reset; software fills it before use
	always_ff @(posedge clk)
	begin
		if (wr_en)
			mem[wr_idx] <= wr_data;
	end
	// Registered read ports, one cycle latency
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			rd_a_data <= `AIH_RST_WORD;
			rd_b_data <= `AIH_RST_WORD;
		end
		else
		begin
			rd_a_data <= mem[rd_a_idx];
			rd_b_data <= mem[rd_b_idx];
		end
	end
endmodule : aih_regfile
`default_nettype wire

/* File: sim/aih_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Far-side memory behind a one-master arbiter
module aih_mem_model (
	input  wire logic                  clk,
	input  wire logic                  sys_rst,
	input  wire logic                  slow,
	input  wire aih_pkg::aih_bus_t     bus_out,
	output var  aih_pkg::aih_bus_rsp_t bus_rsp
);
	import aih_pkg::*;
	logic [31:0] mem [0:15];  // Sixteen words, picked by addr[5:2]
	logic [1:0]  wait_cnt;    // Stall cycles spent on this access
	// Ack after an optional stall; stale read data never lingers
	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			bus_rsp  <= '0;
			wait_cnt <= 2'h0;
		end
		else if (bus_rsp.ack)
		begin
			bus_rsp.ack   <= 1'b0;
			bus_rsp.rdata <= ~bus_rsp.rdata;  // Hold time over, show junk
		end
		else if (bus_out.req && wait_cnt < (slow ? 2'h3 : 2'h0))
			wait_cnt <= wait_cnt + 2'h1;  // Slow answer
		else if (bus_out.req)
		begin
			// Only master on the bus, so a locked pair stays atomic
			wait_cnt    <= 2'h0;
			bus_rsp.ack <= 1'b1;
			if (bus_out.we)
				mem[bus_out.addr[5:2]] <= bus_out.wdata;
			bus_rsp.rdata <= bus_out.we ? ~bus_out.wdata : mem[bus_out.addr[5:2]];
		end
		else
			bus_rsp.rdata <= ~bus_rsp.rdata;  // Idle bus keeps changing
	end
endmodule : aih_mem_model
`default_nettype wire

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "aih_consts.svh"
`define CHK(a, e, m) begin total_checks++; if ((a) !== (e)) \
	begin bad_count++; $display("CHECK FAILED at %0t: %s", $time, m); end end
module tb_top;
	import aih_pkg::*;
	typedef struct packed {logic we; logic lock; logic [31:0] addr; logic [31:0] wdata;} aih_tb_bus_t;
	typedef struct packed {logic bad; logic lk; logic c; logic v;} aih_tb_done_t;
	logic         clk, sys_rst, instr_valid, instr_ready, instr_bad, done, pipe_empty;
	logic         acc_in_cache, carry_flag, overflow_flag, fwd_valid, slow, fc, fv;
	logic [31:0]  acc_mem_addr, fwd_result, seed, acc;  // acc is the expected accumulator
	logic [31:0]  shadow [0:15];                       // Expected memory contents
	aih_instr_t   instr;
	aih_bus_t     bus_out;
	aih_bus_rsp_t bus_rsp;
	aih_tb_bus_t  bn;
	aih_tb_done_t dn;
	int           bad_count, total_checks, cyc;
	logic [31:0]  fq [$];   // Expected forwarded sums
	aih_tb_done_t dq [$];   // Expected completions
	aih_tb_bus_t  bq [$];   // Expected bus accesses, in order
	aih_core dut (.clk(clk), .sys_rst(sys_rst), .instr_valid(instr_valid), .instr(instr),
		.instr_ready(instr_ready), .instr_bad(instr_bad), .done(done), .pipe_empty(pipe_empty),
		.acc_in_cache(acc_in_cache), .acc_mem_addr(acc_mem_addr), .bus_out(bus_out), .bus_rsp(bus_rsp),
		.carry_flag(carry_flag), .overflow_flag(overflow_flag), .fwd_result(fwd_result), .fwd_valid(fwd_valid));
	aih_mem_model pm (.clk(clk), .sys_rst(sys_rst), .slow(slow), .bus_out(bus_out), .bus_rsp(bus_rsp));
	// Clock at 125 MHz
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Xorshift source
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs
	// Reference sum: {carry, overflow, untruncated sum}
	function automatic logic [33:0] ref_add(input logic nar, input logic [31:0] d, input logic [31:0] s);
		logic [32:0] w;
		logic [16:0] n;
		w = {1'b0, d} + {1'b0, s};
		n = {1'b0, d[15:0]} + {1'b0, s[15:0]};
		if (nar)
			return {n[16], (d[15] == s[15]) && (n[15] != d[15]), 15'h0, n};
		return {w[32], (d[31] == s[31]) && (w[31] != d[31]), w[31:0]};
	endfunction : ref_add
	// Instruction builder; short forms always aim at stack word 1
	function automatic aih_instr_t mk(input logic [3:0] len, input logic [7:0] op, input logic [4:0] sf,
		input logic [31:0] gs, input logic gm, input logic [4:0] gi);
		return '{len:len, opcode:op, src_fld:sf, dst_fld:5'h01, gsrc:gs, gdst_mem:gm, gdst_idx:gi,
			gdst_addr:{26'h0, gi[3:0], 2'h0}};
	endfunction : mk
	// Offer one instruction and hold it until taken
	task issue(input aih_instr_t i);
		@(posedge clk);
		#1;
		instr_valid = 1'b1;
		instr = i;
		while (instr_ready !== 1'b1)
		begin
			@(posedge clk);
			#1;
		end
		@(posedge clk);
		#1;
		instr_valid = 1'b0;
	endtask : issue
	// General add with its destination in memory
	task gen_op(input logic [3:0] len, input logic [7:0] op, input logic [3:0] k, input logic [31:0] s);
		logic [33:0] r;
		logic [31:0] st;
		r = ref_add(len == `AIH_LEN_GENERAL_OPERAND_16, shadow[k], s);
		st = (len == `AIH_LEN_GENERAL_OPERAND_16) ? {shadow[k][31:16], r[15:0]} : r[31:0];
		fc = r[33];
		fv = r[32];
		bq.push_back('{1'b0, 1'b0, {26'h0, k, 2'h0}, 32'h0});
		if (op == `AIH_OP_ADD_GEN)
		begin
			bq.push_back('{1'b1, 1'b0, {26'h0, k, 2'h0}, st});
			shadow[k] = st;
		end
		else
			acc = st;  // Memory left alone
		fq.push_back(r[31:0]);
		dq.push_back('{1'b0, 1'b0, fc, fv});
		issue(mk(len, op, 5'h0, s, 1'b1, {1'b0, k}));
	endtask : gen_op
	// Short form on the accumulator word
	task short_op(input logic [7:0] op, input logic [4:0] sf);
		logic [31:0] s;
		logic [33:0] r;
		case (op)
			`AIH_OP_ACC_WAI: s = {25'h0, sf, 2'h0};
			`AIH_OP_ADD_IMM, `AIH_OP_ACC_IMM: s = {{27{sf[4]}}, sf};
			default: s = acc;
		endcase
		r = ref_add(1'b0, acc, s);
		acc = r[31:0];
		fc = r[33];
		fv = r[32];
		fq.push_back(r[31:0]);
		dq.push_back('{1'b0, 1'b0, fc, fv});
		issue(mk(`AIH_LEN_SHORT, op, sf, 32'h0, 1'b0, 5'h0));
	endtask : short_op
	// Interlocked add; pipeline held busy for a while first
	task lock_op(input logic [3:0] len, input logic gm, input logic [3:0] k, input logic [31:0] s,
		input logic inc);
		logic [33:0] r;
		logic [31:0] old;
		logic [31:0] st;
		while (instr_ready !== 1'b1)
		begin
			@(posedge clk);
			#1;
		end
		old = gm ? shadow[k] : acc;
		r = ref_add(len == `AIH_LEN_GENERAL_OPERAND_16, old, s);
		st = (len == `AIH_LEN_GENERAL_OPERAND_16) ? {old[31:16], r[15:0]} : r[31:0];
		if (gm)
		begin
			bq.push_back('{1'b0, 1'b1, {26'h0, k, 2'h0}, 32'h0});
			bq.push_back('{1'b1, 1'b1, {26'h0, k, 2'h0}, st});
			shadow[k] = st;
			if (!inc)
				bq.push_back('{1'b1, 1'b0, acc_mem_addr, old});
		end
		acc = old;
		dq.push_back('{1'b0, 1'b1, fc, fv});
		acc_in_cache = inc;
		pipe_empty = 1'b0;
		issue(mk(len, `AIH_OP_LOCK_GEN, 5'h0, s, gm, gm ? {1'b0, k} : 5'h01));
		repeat (4)
		begin
			@(posedge clk);
			#1;
			`CHK({bus_out.req, done}, 2'b00, "activity before drain")
		end
		pipe_empty = 1'b1;
	endtask : lock_op
	// Verdict and end of run
	task tally_and_finish();
		if (bad_count == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : tally_and_finish
	// Watch outputs mid-cycle and retire the oldest notes
	always @(negedge clk)
	begin
		if (sys_rst === 1'b0)
		begin
			if (fwd_valid === 1'b1 && !(dq.size() != 0 && dq[0].lk))
			begin
				`CHK(fq.size() != 0, 1'b1, "surplus result")
				if (fq.size() != 0) `CHK(fwd_result, fq.pop_front(), "forwarded sum")
			end
			if (done === 1'b1 || instr_bad === 1'b1)
			begin
				`CHK(dq.size() != 0, 1'b1, "surplus completion")
				dn = dq.pop_front();
				`CHK(instr_bad, dn.bad, "decode outcome")
				`CHK({carry_flag, overflow_flag}, {dn.c, dn.v}, "flags")
			end
			if (bus_out.req === 1'b1 && bus_rsp.ack === 1'b1)
			begin
				`CHK(bq.size() != 0, 1'b1, "surplus bus access")
				bn = bq.pop_front();
				`CHK({bus_out.we, bus_out.lock, bus_out.addr}, {bn.we, bn.lock, bn.addr}, "bus access")
				if (bn.we) `CHK(bus_out.wdata, bn.wdata, "bus write data")
			end
		end
	end
	// Hang guard
	always @(posedge clk)
	begin
		cyc++;
		if (cyc > 20000)
		begin
			bad_count++;
			tally_and_finish();
		end
	end
	// Main sequence; no flag-word reads, frame setups or shadow reads are issued
	initial
	begin
		logic [31:0] cs [0:3];
		logic [31:0] r;
		sys_rst = 1'b1;
		instr_valid = 1'b0;
		instr = '0;
		pipe_empty = 1'b1;
		acc_in_cache = 1'b1;
		acc_mem_addr = 32'h0000003C;
		slow = 1'b0;
		fc = 1'b0;
		fv = 1'b0;
		seed = 32'h000169BA;  // Seed 92602
		cs = '{32'h7FFFFFFF, 32'hFFFFFFFF, 32'h80000000, 32'h00000001};
		for (int i = 0; i < 16; i++)
			shadow[i] = (i >= 8 && i < 12) ? cs[i - 8] : xs();
		shadow[12] = 32'hABCDFFFF;
		shadow[13] = 32'h12347FFF;
		for (int i = 0; i < 16; i++)
			pm.mem[i] = shadow[i];
		repeat (16) @(posedge clk);
		#1;
		`CHK(instr_ready, 1'b0, "ready in reset")
		sys_rst = 1'b0;
		gen_op(`AIH_LEN_GENERAL_OPERAND_32, `AIH_OP_ACC_GEN, 4'h0, xs());
		for (int i = 0; i < 4; i++)
			gen_op(`AIH_LEN_GENERAL_OPERAND_32, `AIH_OP_ADD_GEN, 4'(8 + i), (i == 2) ? 32'h80000000 : 32'h1);
		gen_op(`AIH_LEN_GENERAL_OPERAND_16, `AIH_OP_ADD_GEN, 4'hC, 32'h1);
		gen_op(`AIH_LEN_GENERAL_OPERAND_16, `AIH_OP_ACC_GEN, 4'hD, 32'h1);
		for (int i = 0; i < 6; i++)
		begin
			r = xs();
			gen_op(r[0] ? `AIH_LEN_GENERAL_OPERAND_16 : `AIH_LEN_GENERAL_OPERAND_32, r[1] ? `AIH_OP_ADD_GEN : `AIH_OP_ACC_GEN, {1'b0, r[4:2]}, xs());
		end
		slow = 1'b1;
		lock_op(`AIH_LEN_GENERAL_OPERAND_16, 1'b1, 4'h5, 32'h1, 1'b1);
		lock_op(`AIH_LEN_GENERAL_OPERAND_32, 1'b1, 4'h3, xs(), 1'b0);
		lock_op(`AIH_LEN_GENERAL_OPERAND_32, 1'b1, 4'h4, xs(), 1'b1);
		short_op(`AIH_OP_ADD_IMM, 5'h00);
		lock_op(`AIH_LEN_GENERAL_OPERAND_32, 1'b0, 4'h1, xs(), 1'b1);
		short_op(`AIH_OP_ADD_IMM, 5'h00);
		slow = 1'b0;
		short_op(`AIH_OP_ACC_WAI, 5'h1F);
		short_op(`AIH_OP_ADD_IMM, 5'h1F);
		short_op(`AIH_OP_ACC_IMM, 5'h10);
		short_op(`AIH_OP_ADD_STK, 5'h01);
		short_op(`AIH_OP_ACC_STK, 5'h01);
		short_op(`AIH_OP_ADD_IMM, 5'h0F);
		// Unknown opcode and length pairs are dropped
		cs = '{32'h00000223, 32'h00000614, 32'h00000203, 32'h00000A0D};
		for (int i = 0; i < 4; i++)
		begin
			dq.push_back('{1'b1, 1'b0, fc, fv});
			issue(mk(cs[i][11:8], cs[i][7:0], 5'h0, 32'h0, 1'b0, 5'h1));
		end
		for (int i = 0; i < 200 && (fq.size() + dq.size() + bq.size()) != 0; i++)
			@(posedge clk);
		#1;
		`CHK(fq.size() + dq.size() + bq.size(), 0, "results outstanding")
		tally_and_finish();
	end
endmodule : tb_top
`default_nettype wire
